// >>> logic/bwsl_board.sv
// Board supervisory block: watchdog with selectable time-out forcing a
// full system reset, front-panel LED decoding and backplane signal routing.
// Assumes every input is an asynchronous pin; service requests arrive as
// rising edges on chipset output pins. Each LED is a red/green pair.
//
// Contract
// - Watchdog time-out selectable by software among 2, 10, 50 and 255 seconds.
// - After system reset the watchdog is passive and needs no boot trigger.
// - The first trigger after reset arms the watchdog.
// - Armed, a gap between triggers above the period forces full system reset.
// - Once armed the watchdog stays armed until the next system reset.
// - A new time-out selection is taken at any time, also while armed.
// - Health LED: off asleep, red hardware fault, red blink, yellow blink, green.
// - Health off: general-purpose and disk LEDs encode S3, S4 or S5.
// - A service request enters blinking-red software failure; the next one leaves.
// - Disk LED off idle, green chipset SATA, yellow extra controller SATA.
// - General-purpose red follows the chipset output, lit at logic one.
// - General-purpose green changes only by a service request.
// - Ethernet LED off, green port one, yellow port two, green/yellow both.
// - Ethernet LED blinks in a port's colour while that port is active.
// - Backplane enumeration line routed to a chipset input.
// - Fail goes to the first chipset input, degrade to the second.
// - Health LED turns green only with supplies good and reset released.
`timescale 1ns/1ps
`include "bwsl_regs.svh"

module bwsl_board #(
    parameter int unsigned SEC_CYCLES = `BWSL_SEC_CYCLES,
    parameter int unsigned BLINK_CYCLES = `BWSL_BLINK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic dog_trigger_request,
    input wire logic [`BWSL_SEL_W-1:0] dog_timeout_sel,
    input wire logic sw_fail_request,
    input wire logic genp_green_request,
    input wire logic genp_green_value,
    input wire logic sleep_s3,
    input wire logic sleep_s4,
    input wire logic sleep_s5,
    input wire logic hw_failure,
    input wire logic handle_unlocked,
    input wire logic supplies_ok,
    input wire logic sata_chipset_activity,
    input wire logic sata_extra_activity,
    input wire logic red_led_chipset_output,
    input wire logic first_backplane_port_link,
    input wire logic second_backplane_port_link,
    input wire logic first_backplane_port_activity,
    input wire logic second_backplane_port_activity,
    input wire logic backplane_enum_n,
    input wire logic supply_fail_n,
    input wire logic supply_degrade_n,
    output logic health_led_red,
    output logic health_led_green,
    output logic disk_activity_led_red,
    output logic disk_activity_led_green,
    output logic general_purpose_led_red,
    output logic general_purpose_led_green,
    output logic backplane_ethernet_led_red,
    output logic backplane_ethernet_led_green,
    output logic enumeration_chipset_input_n,
    output logic supply_fail_chipset_input_n,
    output logic supply_degrade_chipset_input_n,
    output logic system_reset_request,
    output logic dog_armed
);
    bwsl_pkg::bwsl_main_st_t st;
    bwsl_pkg::bwsl_main_st_t next_st;
    logic sec_tick;
    logic blink;
    logic trig_edge;
    logic dog_expired;
    bwsl_pkg::bwsl_secs_t dog_secs;
    logic [`BWSL_IN_W-1:0] pins;
    logic [`BWSL_IN_W-1:0] s;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Pin gathering
    always_comb begin
        pins = '0;
        pins[`BWSL_IN_TRIG] = dog_trigger_request;
        pins[`BWSL_IN_SWREQ] = sw_fail_request;
        pins[`BWSL_IN_GPREQ] = genp_green_request;
        pins[`BWSL_IN_GPVAL] = genp_green_value;
        pins[`BWSL_IN_S3] = sleep_s3;
        pins[`BWSL_IN_S4] = sleep_s4;
        pins[`BWSL_IN_S5] = sleep_s5;
        pins[`BWSL_IN_HWFAIL] = hw_failure;
        pins[`BWSL_IN_UNLOCK] = handle_unlocked;
        pins[`BWSL_IN_SUPOK] = supplies_ok;
        pins[`BWSL_IN_SATA_CHIP] = sata_chipset_activity;
        pins[`BWSL_IN_SATA_EXT] = sata_extra_activity;
        pins[`BWSL_IN_RED_GPO] = red_led_chipset_output;
        pins[`BWSL_IN_LINK1] = first_backplane_port_link;
        pins[`BWSL_IN_LINK2] = second_backplane_port_link;
        pins[`BWSL_IN_ACT1] = first_backplane_port_activity;
        pins[`BWSL_IN_ACT2] = second_backplane_port_activity;
        pins[`BWSL_IN_SEL0] = dog_timeout_sel[0];
        pins[`BWSL_IN_SEL1] = dog_timeout_sel[1];
        pins[`BWSL_IN_ENUM_N] = backplane_enum_n;
        pins[`BWSL_IN_FAIL_N] = supply_fail_n;
        pins[`BWSL_IN_DEG_N] = supply_degrade_n;
    end

    assign s = st.sync2;
    assign trig_edge = s[`BWSL_IN_TRIG] & ~st.prev_trig;

    ////////////////////////////////////////////////////////////////////////////
    // Timebase and watchdog unit
    bwsl_tick #(
        .SEC_CYCLES(SEC_CYCLES),
        .BLINK_CYCLES(BLINK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .sec_tick(sec_tick),
        .blink(blink)
    );

    bwsl_wdog u_wdog (
        .core_clk(core_clk),
        .rst(rst),
        .sec_tick(sec_tick),
        .trigger(trig_edge),
        .timeout_sel({s[`BWSL_IN_SEL1], s[`BWSL_IN_SEL0]}),
        .armed(dog_armed),
        .expired(dog_expired),
        .secs(dog_secs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic sleep;
        logic c1;
        logic c2;
        sleep = 1'b0;
        c1 = 1'b0;
        c2 = 1'b0;
        next_st = st;
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        next_st.prev_trig = s[`BWSL_IN_TRIG];
        next_st.prev_swreq = s[`BWSL_IN_SWREQ];
        next_st.prev_gpreq = s[`BWSL_IN_GPREQ];
        if (s[`BWSL_IN_SWREQ] && !st.prev_swreq) begin
            next_st.sw_fail = ~st.sw_fail;
        end
        if (s[`BWSL_IN_GPREQ] && !st.prev_gpreq) begin
            next_st.genp_green = s[`BWSL_IN_GPVAL];
        end
        if (sec_tick) begin
            next_st.alt = ~st.alt;
        end
        sleep = s[`BWSL_IN_S3] | s[`BWSL_IN_S4] | s[`BWSL_IN_S5];

        // Health indication, highest cause first
        if (sleep) begin
            next_st.health = `BWSL_LED_OFF;
        end else if (s[`BWSL_IN_HWFAIL]) begin
            next_st.health = `BWSL_LED_RED;
        end else if (st.sw_fail) begin
            next_st.health = blink ? `BWSL_LED_RED : `BWSL_LED_OFF;
        end else if (s[`BWSL_IN_UNLOCK]) begin
            next_st.health = blink ? `BWSL_LED_YELLOW : `BWSL_LED_OFF;
        end else if (s[`BWSL_IN_SUPOK]) begin
            next_st.health = `BWSL_LED_GREEN;
        end else begin
            next_st.health = `BWSL_LED_OFF;
        end

        // Disk and general-purpose LEDs; sleep code overrides both
        if (s[`BWSL_IN_S5]) begin
            next_st.genp = `BWSL_LED_GREEN;
            next_st.disk = `BWSL_LED_GREEN;
        end else if (s[`BWSL_IN_S4]) begin
            next_st.genp = `BWSL_LED_GREEN;
            next_st.disk = `BWSL_LED_OFF;
        end else if (s[`BWSL_IN_S3]) begin
            next_st.genp = `BWSL_LED_OFF;
            next_st.disk = `BWSL_LED_GREEN;
        end else begin
            next_st.genp = {s[`BWSL_IN_RED_GPO], st.genp_green};
            if (s[`BWSL_IN_SATA_EXT]) begin
                next_st.disk = `BWSL_LED_YELLOW;
            end else if (s[`BWSL_IN_SATA_CHIP]) begin
                next_st.disk = `BWSL_LED_GREEN;
            end else begin
                next_st.disk = `BWSL_LED_OFF;
            end
        end

        // Backplane Ethernet: both linked alternates colours each second
        c1 = s[`BWSL_IN_LINK1] & (~s[`BWSL_IN_ACT1] | blink);
        c2 = s[`BWSL_IN_LINK2] & (~s[`BWSL_IN_ACT2] | blink);
        if (s[`BWSL_IN_LINK1] && s[`BWSL_IN_LINK2]) begin
            if (st.alt) begin
                next_st.eth = c2 ? `BWSL_LED_YELLOW : `BWSL_LED_OFF;
            end else begin
                next_st.eth = c1 ? `BWSL_LED_GREEN : `BWSL_LED_OFF;
            end
        end else if (s[`BWSL_IN_LINK1]) begin
            next_st.eth = c1 ? `BWSL_LED_GREEN : `BWSL_LED_OFF;
        end else if (s[`BWSL_IN_LINK2]) begin
            next_st.eth = c2 ? `BWSL_LED_YELLOW : `BWSL_LED_OFF;
        end else begin
            next_st.eth = `BWSL_LED_OFF;
        end

        next_st.enum_n = s[`BWSL_IN_ENUM_N];
        next_st.fail_n = s[`BWSL_IN_FAIL_N];
        next_st.deg_n = s[`BWSL_IN_DEG_N];
        // Held until the system reset it causes comes back on rst
        next_st.sys_reset = st.sys_reset | dog_expired;

        if (rst) begin
            next_st = '0;
            next_st.sync1 = `BWSL_SYNC_RST;
            next_st.sync2 = `BWSL_SYNC_RST;
            next_st.prev_trig = 1'b1;
            next_st.prev_swreq = 1'b1;
            next_st.prev_gpreq = 1'b1;
            next_st.genp_green = `BWSL_GENP_GREEN_RST;
            next_st.enum_n = `BWSL_ROUTE_N_RST;
            next_st.fail_n = `BWSL_ROUTE_N_RST;
            next_st.deg_n = `BWSL_ROUTE_N_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign health_led_red = st.health[1];
    assign health_led_green = st.health[0];
    assign disk_activity_led_red = st.disk[1];
    assign disk_activity_led_green = st.disk[0];
    assign general_purpose_led_red = st.genp[1];
    assign general_purpose_led_green = st.genp[0];
    assign backplane_ethernet_led_red = st.eth[1];
    assign backplane_ethernet_led_green = st.eth[0];
    assign enumeration_chipset_input_n = st.enum_n;
    assign supply_fail_chipset_input_n = st.fail_n;
    assign supply_degrade_chipset_input_n = st.deg_n;
    assign system_reset_request = st.sys_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_sleep_health_off: assert property (
        (s[`BWSL_IN_S3] || s[`BWSL_IN_S4] || s[`BWSL_IN_S5]) |=> !health_led_red && !health_led_green)
        else $error("health LED lit while asleep");
    a_hw_fail_red: assert property (
        !(s[`BWSL_IN_S3] || s[`BWSL_IN_S4] || s[`BWSL_IN_S5]) && s[`BWSL_IN_HWFAIL]
        |=> health_led_red && !health_led_green)
        else $error("hardware failure not steady red");
    a_green_needs_ok: assert property (
        health_led_green && !health_led_red |-> $past(s[`BWSL_IN_SUPOK]) && !$past(rst))
        else $error("health green without good supplies");
    a_sw_fail_toggle: assert property (
        s[`BWSL_IN_SWREQ] && !st.prev_swreq |=> st.sw_fail != $past(st.sw_fail))
        else $error("service request did not toggle software failure");
    a_sleep_s3_code: assert property (
        s[`BWSL_IN_S3] && !s[`BWSL_IN_S4] && !s[`BWSL_IN_S5]
        |=> st.genp == `BWSL_LED_OFF && st.disk == `BWSL_LED_GREEN)
        else $error("S3 code wrong");
    a_red_genp_follow: assert property (
        !(s[`BWSL_IN_S3] || s[`BWSL_IN_S4] || s[`BWSL_IN_S5])
        |=> general_purpose_led_red == $past(s[`BWSL_IN_RED_GPO]))
        else $error("red element does not follow chipset output");
    a_genp_green_hold: assert property (
        !(s[`BWSL_IN_GPREQ] && !st.prev_gpreq) |=> st.genp_green == $past(st.genp_green))
        else $error("green element changed without request");
    a_disk_extra_yellow: assert property (
        !(s[`BWSL_IN_S3] || s[`BWSL_IN_S4] || s[`BWSL_IN_S5]) && s[`BWSL_IN_SATA_EXT]
        |=> st.disk == `BWSL_LED_YELLOW)
        else $error("extra controller access not yellow");
    a_eth_no_link: assert property (
        !s[`BWSL_IN_LINK1] && !s[`BWSL_IN_LINK2] |=> st.eth == `BWSL_LED_OFF)
        else $error("Ethernet LED lit without link");
    a_route_fail: assert property (
        ##1 supply_fail_chipset_input_n == $past(s[`BWSL_IN_FAIL_N])
            && supply_degrade_chipset_input_n == $past(s[`BWSL_IN_DEG_N]))
        else $error("supply lines misrouted");
    a_route_enum: assert property (
        ##1 enumeration_chipset_input_n == $past(s[`BWSL_IN_ENUM_N]))
        else $error("enumeration line misrouted");
    a_reset_request: assert property (
        dog_expired |=> system_reset_request [*2])
        else $error("expiry did not request system reset");
    c_sw_fail: cover property ($rose(st.sw_fail));
    c_both_links: cover property (s[`BWSL_IN_LINK1] && s[`BWSL_IN_LINK2] && st.eth == `BWSL_LED_YELLOW);
    c_reset_request: cover property ($rose(system_reset_request));

endmodule // bwsl_board

// >>> logic/bwsl_pkg.sv
// Types and decode function of the board watchdog and status LED block.
// Assumes bwsl_regs.svh is on the include path.
`include "bwsl_regs.svh"

package bwsl_pkg;

    typedef logic [`BWSL_CNT_W-1:0] bwsl_secs_t;
    typedef logic [1:0] bwsl_led_t;

    typedef enum logic [1:0] {DOG_PASSIVE, DOG_ARMED, DOG_EXPIRED} bwsl_dog_t;

    typedef struct packed {
        logic [`BWSL_DIV_W-1:0] sec_cnt;
        logic [`BWSL_DIV_W-1:0] blink_cnt;
        logic sec_tick;
        logic blink;
    } bwsl_tick_st_t;

    typedef struct packed {
        bwsl_dog_t state;
        bwsl_secs_t secs;
    } bwsl_dog_st_t;

    typedef struct packed {
        logic [`BWSL_IN_W-1:0] sync1;
        logic [`BWSL_IN_W-1:0] sync2;
        logic prev_trig;
        logic prev_swreq;
        logic prev_gpreq;
        logic sw_fail;
        logic genp_green;
        logic alt;
        bwsl_led_t health;
        bwsl_led_t disk;
        bwsl_led_t genp;
        bwsl_led_t eth;
        logic enum_n;
        logic fail_n;
        logic deg_n;
        logic sys_reset;
    } bwsl_main_st_t;

    // Time-out in seconds for a selection code
    function automatic bwsl_secs_t bwsl_limit(input logic [`BWSL_SEL_W-1:0] sel);
        case (sel)
            2'h0: bwsl_limit = `BWSL_TO_SEL0_S;
            2'h1: bwsl_limit = `BWSL_TO_SEL1_S;
            2'h2: bwsl_limit = `BWSL_TO_SEL2_S;
            default: bwsl_limit = `BWSL_TO_SEL3_S;
        endcase
    endfunction

endpackage

// >>> logic/bwsl_regs.svh
// Constants of the board watchdog and status LED block: field positions,
// reset values, timing figures and time-out choices.
// Assumes a single 100 MHz board clock.
`ifndef BWSL_REGS_SVH
`define BWSL_REGS_SVH

`define BWSL_CLK_HZ 100000000
`define BWSL_SEC_S 1
`define BWSL_SEC_CYCLES (`BWSL_SEC_S * `BWSL_CLK_HZ)
`define BWSL_BLINK_MS 250
`define BWSL_BLINK_CYCLES ((`BWSL_CLK_HZ / 1000) * `BWSL_BLINK_MS)
`define BWSL_DIV_W 27

`define BWSL_SEL_W 2
`define BWSL_CNT_W 8
`define BWSL_TO_SEL0_S 8'h02
`define BWSL_TO_SEL1_S 8'h0A
`define BWSL_TO_SEL2_S 8'h32
`define BWSL_TO_SEL3_S 8'hFF

`define BWSL_LED_OFF 2'h0
`define BWSL_LED_GREEN 2'h1
`define BWSL_LED_RED 2'h2
`define BWSL_LED_YELLOW 2'h3

`define BWSL_IN_W 22
`define BWSL_IN_TRIG 0
`define BWSL_IN_SWREQ 1
`define BWSL_IN_GPREQ 2
`define BWSL_IN_GPVAL 3
`define BWSL_IN_S3 4
`define BWSL_IN_S4 5
`define BWSL_IN_S5 6
`define BWSL_IN_HWFAIL 7
`define BWSL_IN_UNLOCK 8
`define BWSL_IN_SUPOK 9
`define BWSL_IN_SATA_CHIP 10
`define BWSL_IN_SATA_EXT 11
`define BWSL_IN_RED_GPO 12
`define BWSL_IN_LINK1 13
`define BWSL_IN_LINK2 14
`define BWSL_IN_ACT1 15
`define BWSL_IN_ACT2 16
`define BWSL_IN_SEL0 17
`define BWSL_IN_SEL1 18
`define BWSL_IN_ENUM_N 19
`define BWSL_IN_FAIL_N 20
`define BWSL_IN_DEG_N 21
`define BWSL_SYNC_RST 22'h380000

`define BWSL_GENP_GREEN_RST 1'b0
`define BWSL_ROUTE_N_RST 1'b1

`endif

// >>> logic/bwsl_tick.sv
// Divider: one-cycle seconds tick and a free-running blink level.
// Assumes the board clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "bwsl_regs.svh"

module bwsl_tick #(
    parameter int unsigned SEC_CYCLES = `BWSL_SEC_CYCLES,
    parameter int unsigned BLINK_CYCLES = `BWSL_BLINK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    output logic sec_tick,
    output logic blink
);
    localparam int DW = `BWSL_DIV_W;

    bwsl_pkg::bwsl_tick_st_t st;
    bwsl_pkg::bwsl_tick_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.sec_tick = 1'b0;
        if (st.sec_cnt >= DW'(SEC_CYCLES - 1)) begin
            next_st.sec_cnt = '0;
            next_st.sec_tick = 1'b1;
        end else begin
            next_st.sec_cnt = st.sec_cnt + DW'(1);
        end
        if (st.blink_cnt >= DW'(BLINK_CYCLES - 1)) begin
            next_st.blink_cnt = '0;
            next_st.blink = ~st.blink;
        end else begin
            next_st.blink_cnt = st.blink_cnt + DW'(1);
        end
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign sec_tick = st.sec_tick;
    assign blink = st.blink;

endmodule // bwsl_tick

// >>> logic/bwsl_wdog.sv
// Watchdog unit: passive after reset, armed by the first trigger,
// expires when the seconds since the last trigger pass the selected time-out.
// Assumes trigger is a one-cycle pulse and sec_tick a one-cycle enable.
`timescale 1ns/1ps
`include "bwsl_regs.svh"

module bwsl_wdog (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sec_tick,
    input wire logic trigger,
    input wire logic [`BWSL_SEL_W-1:0] timeout_sel,
    output logic armed,
    output logic expired,
    output bwsl_pkg::bwsl_secs_t secs
);
    bwsl_pkg::bwsl_dog_st_t st;
    bwsl_pkg::bwsl_dog_st_t next_st;

    always_comb begin
        next_st = st;
        case (st.state)
            bwsl_pkg::DOG_PASSIVE: begin
                if (trigger) begin
                    next_st.state = bwsl_pkg::DOG_ARMED;
                    next_st.secs = '0;
                end
            end
            bwsl_pkg::DOG_ARMED: begin
                if (trigger) begin
                    next_st.secs = '0;
                end else if (sec_tick) begin
                    // Live selection, so a new time-out acts at once
                    if (st.secs >= bwsl_pkg::bwsl_limit(timeout_sel)) begin
                        next_st.state = bwsl_pkg::DOG_EXPIRED;
                    end else begin
                        next_st.secs = st.secs + 8'h01;
                    end
                end
            end
            bwsl_pkg::DOG_EXPIRED: begin
                next_st.state = bwsl_pkg::DOG_EXPIRED;
            end
            default: begin
                next_st.state = bwsl_pkg::DOG_PASSIVE;
            end
        endcase
        if (rst) begin
            next_st.state = bwsl_pkg::DOG_PASSIVE;
            next_st.secs = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign armed = (st.state != bwsl_pkg::DOG_PASSIVE);
    assign expired = (st.state == bwsl_pkg::DOG_EXPIRED);
    assign secs = st.secs;

    ////////////////////////////////////////////////////////////////////////////
    a_passive_after_reset: assert property (@(posedge core_clk) disable iff (rst)
        $past(rst) |-> !armed && secs == 8'h00)
        else $error("watchdog not passive after reset");
    a_arm_on_trigger: assert property (@(posedge core_clk) disable iff (rst)
        trigger |=> armed)
        else $error("trigger did not arm watchdog");
    a_stays_armed: assert property (@(posedge core_clk) disable iff (rst)
        armed |=> armed)
        else $error("watchdog left armed state");
    a_expire_at_limit: assert property (@(posedge core_clk) disable iff (rst)
        $rose(expired) |-> $past(sec_tick) && !$past(trigger)
            && $past(secs) >= bwsl_pkg::bwsl_limit($past(timeout_sel)))
        else $error("watchdog expired early");
    a_restart_count: assert property (@(posedge core_clk) disable iff (rst)
        trigger && !expired |=> secs == 8'h00 && !expired)
        else $error("trigger did not restart count");
    a_sel_any_time: assert property (@(posedge core_clk) disable iff (rst)
        armed && !trigger && sec_tick && secs >= bwsl_pkg::bwsl_limit(timeout_sel) |=> expired)
        else $error("selected time-out not applied");
    c_armed: cover property (@(posedge core_clk) disable iff (rst) $rose(armed));
    c_expired: cover property (@(posedge core_clk) disable iff (rst) $rose(expired));

endmodule // bwsl_wdog

// >>> verif/board_watchdog_status_leds_tb_top.sv
// Testbench of the board watchdog and status LED block.
// Assumes short divider parameters: 20 cycles a second, 4 a blink phase.
`timescale 1ns/1ps

module board_watchdog_status_leds_tb_top;
    localparam int SEC = 20;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [21:0] p = 22'h380000;
    logic [1:0] sel = 2'h0;
    logic [2:0] cmd = 3'h0;
    logic [2:0] req;
    logic [7:0] leds;
    logic [2:0] rt;
    logic armed;
    logic rreq;
    int error_cnt = 0;
    int tests_run = 0;
    int lim;
    logic [7:0] m;

    bwsl_host_model u_bwsl_host_model (.core_clk(core_clk), .cmd(cmd), .req(req));
    bwsl_board #(.SEC_CYCLES(SEC), .BLINK_CYCLES(4)) u_bwsl_board (.core_clk(core_clk), .rst(rst),
        .dog_trigger_request(req[0]), .dog_timeout_sel(sel), .sw_fail_request(req[1]),
        .genp_green_request(req[2]), .genp_green_value(p[3]), .sleep_s3(p[4]), .sleep_s4(p[5]),
        .sleep_s5(p[6]), .hw_failure(p[7]), .handle_unlocked(p[8]), .supplies_ok(p[9]),
        .sata_chipset_activity(p[10]), .sata_extra_activity(p[11]), .red_led_chipset_output(p[12]),
        .first_backplane_port_link(p[13]), .second_backplane_port_link(p[14]),
        .first_backplane_port_activity(p[15]), .second_backplane_port_activity(p[16]),
        .backplane_enum_n(p[19]), .supply_fail_n(p[20]), .supply_degrade_n(p[21]),
        .health_led_red(leds[7]), .health_led_green(leds[6]), .disk_activity_led_red(leds[5]),
        .disk_activity_led_green(leds[4]), .general_purpose_led_red(leds[3]),
        .general_purpose_led_green(leds[2]), .backplane_ethernet_led_red(leds[1]),
        .backplane_ethernet_led_green(leds[0]), .enumeration_chipset_input_n(rt[2]),
        .supply_fail_chipset_input_n(rt[1]), .supply_degrade_chipset_input_n(rt[0]),
        .system_reset_request(rreq), .dog_armed(armed));

    initial forever #5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Expected LED pairs {red,green}: health, disk, general purpose, ethernet
    function automatic logic [7:0] exp_leds(input logic [21:0] q, input logic g);
        logic [1:0] h;
        logic [1:0] d;
        logic [1:0] gl;
        h = q[7] ? 2'h2 : (q[9] ? 2'h1 : 2'h0);
        d = q[11] ? 2'h3 : {1'b0, q[10]};
        gl = {q[12], g};
        if (q[4] | q[5] | q[6]) begin
            h = 2'h0;
            gl = {1'b0, q[5] | q[6]};
            d = {1'b0, q[6] | (q[4] & ~q[5])};
        end
        exp_leds = {h, d, gl, q[14], q[13] | q[14]};
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_blink(input string n, input logic eth, input logic [1:0] c);
        int on;
        int off;
        int bad;
        logic [1:0] v;
        on = 0;
        off = 0;
        bad = 0;
        repeat (24) begin
            @(negedge core_clk);
            v = eth ? leds[1:0] : leds[7:6];
            if (v === c) on++;
            else if (v === 2'h0) off++;
            else bad++;
        end
        chk(n, 8'h07, {5'h00, on > 0, off > 0, bad == 0});
    endtask

    task automatic settle();
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic pulse(input int b);
        @(posedge core_clk) cmd[b] <= 1'b1;
        @(posedge core_clk) cmd[b] <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic drive(input logic [21:0] v);
        @(posedge core_clk) p <= v;
        settle();
    endtask

    task automatic stop_test();
        $display("errors %0d tests %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        stop_test();
    end

    initial begin
        void'($urandom(7));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        chk("wd idle", 8'h00, {6'h00, armed, rreq});
        drive(22'h380208);
        pulse(2);
        @(negedge core_clk);
        chk("gp green", 8'h44, leds);
        repeat (40) begin
            drive(22'($urandom) & 22'h387EF8);
            // Both links alternate green and yellow, so the red element is not compared then
            m = (p[14:13] == 2'h3) ? 8'hFD : 8'hFF;
            chk("leds", exp_leds(p, 1'b1) & m, leds & m);
            chk("route", {5'h00, p[19], p[20], p[21]}, {5'h00, rt});
        end
        drive(22'h380200);
        pulse(1);
        chk_blink("sw fail", 1'b0, 2'h2);
        pulse(1);
        @(negedge core_clk);
        chk("sw back", 8'h01, {6'h00, leds[7:6]});
        drive(22'h380300);
        chk_blink("unlock", 1'b0, 2'h3);
        drive(22'h38A200);
        chk_blink("eth act", 1'b1, 2'h1);
        drive(22'h394200);
        chk_blink("eth act2", 1'b1, 2'h3);
        chk("wd boot", 8'h00, {6'h00, armed, rreq});
        repeat (4) begin
            pulse(0);
            repeat (20) @(posedge core_clk);
        end
        @(negedge core_clk);
        chk("keep alive", 8'h02, {6'h00, armed, rreq});
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk) rst <= 1'b1;
            sel <= (i == 4) ? 2'h3 : 2'(i);
            repeat (4) @(posedge core_clk);
            rst <= 1'b0;
            settle();
            chk("wd reset", 8'h00, {6'h00, armed, rreq});
            lim = (i == 0 || i == 4) ? 2 : (i == 1 ? 10 : (i == 2 ? 50 : 255));
            pulse(0);
            if (i == 4) sel <= 2'h0;
            @(negedge core_clk);
            chk("wd armed", 8'h02, {6'h00, armed, rreq});
            repeat (lim * SEC - 9) @(posedge core_clk);
            @(negedge core_clk);
            chk("wd early", 8'h02, {6'h00, armed, rreq});
            repeat (SEC + 8) @(posedge core_clk);
            pulse(0);
            @(negedge core_clk);
            chk("wd expiry", 8'h03, {6'h00, armed, rreq});
        end
        stop_test();
    end
endmodule // board_watchdog_status_leds_tb_top

// >>> verif/bwsl_host_model.sv
// Host side model: chipset output pins that carry the service requests.
// Assumes one-cycle commands from the bench, at least 6 cycles apart.
`timescale 1ns/1ps

module bwsl_host_model (
    input wire logic core_clk,
    input wire logic [2:0] cmd,
    output logic [2:0] req
);
    logic [2:0] d1 = 3'h0;
    logic [2:0] d2 = 3'h0;
    // Stretch each request to 3 cycles so the synchroniser sees one clean edge
    always_ff @(posedge core_clk) begin
        d1 <= cmd;
        d2 <= d1;
        req <= cmd | d1 | d2;
    end
endmodule // bwsl_host_model
